// File: logic/dbp_pkg.sv
/*
  dbp_pkg: shared constants and types for the two-port general-purpose I/O block.
  Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
*/
`default_nettype none

package dbp_pkg;

  // ==========================================================================
  // port widths
  localparam int unsigned DBP_A_W = 8;
  localparam int unsigned DBP_B_W = 5;

  // ==========================================================================
  // register indices; byte address is four times the index
  localparam logic [9:0] DBP_IDX_A_IN  = 10'h0d0;
  localparam logic [9:0] DBP_IDX_A_OUT = 10'h0d1;
  localparam logic [9:0] DBP_IDX_A_DIR = 10'h0d2;
  localparam logic [9:0] DBP_IDX_A_SFR = 10'h0d3;
  localparam logic [9:0] DBP_IDX_B_IN  = 10'h0d4;
  localparam logic [9:0] DBP_IDX_B_OUT = 10'h0d5;
  localparam logic [9:0] DBP_IDX_B_DIR = 10'h0d6;
  localparam logic [9:0] DBP_IDX_B_SFR = 10'h0d7;

  // ==========================================================================
  // reset values: every bit an input, alternate functions and open drain off
  localparam logic [7:0] DBP_RST_IN  = 8'h00;
  localparam logic [7:0] DBP_RST_OUT = 8'h00;
  localparam logic [7:0] DBP_RST_DIR = 8'h00;
  localparam logic [7:0] DBP_RST_SFR = 8'h00;

  // ==========================================================================
  // second port alternate-function bit positions
  localparam int unsigned DBP_B_CMP_BIT = 0;
  localparam int unsigned DBP_B_TMR_BIT = 1;
  localparam int unsigned DBP_B_SMR_BIT = 2;
  localparam int unsigned DBP_B_IRQ_LO  = 3;

  // ==========================================================================
  // bus responses
  localparam logic [1:0] DBP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DBP_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // pad bundles: level driven and enable, enable high while driving
  typedef struct packed {
    logic [DBP_A_W-1:0] out;
    logic [DBP_A_W-1:0] oe;
  } dbp_a_pad_t;

  typedef struct packed {
    logic [DBP_B_W-1:0] out;
    logic [DBP_B_W-1:0] oe;
  } dbp_b_pad_t;

endpackage

`default_nettype wire

// File: logic/dbp_ports.sv
/*
  dbp_ports: two general-purpose I/O ports (8-bit first port, 5-bit second
  port) with per-bit direction, open drain on the first port, alternate
  functions on the second port, and an AXI4-Lite register slave.
  Assumes pins arrive asynchronously and pads resolve level from out/oe.

*/
`timescale 1ns/10ps
`default_nettype none

module dbp_ports
  import dbp_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // axi4-lite write address
  input  wire logic [11:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // axi4-lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  // axi4-lite read data
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // first port pins
  input  wire logic [DBP_A_W-1:0] first_port_pin_in,
  output dbp_a_pad_t              first_port_pad,
  // second port pins
  input  wire logic [DBP_B_W-1:0] second_port_pin_in,
  output dbp_b_pad_t              second_port_pad,
  // alternate functions of the second port
  input  wire logic               timer_zero_output,
  output logic                    comparator_input,
  output logic                    stop_mode_recovery_input,
  output logic [1:0]              external_interrupt_input
);

  // ==========================================================================
  // address decode
  // misaligned or out-of-map addresses decode to zero and are answered with an error
  function automatic logic [3:0] dbp_decode(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    if ((addr[1:0] == 2'h0) && (idx >= DBP_IDX_A_IN) && (idx <= DBP_IDX_B_SFR))
      dbp_decode = {1'b1, idx[2:0]};
    else
      dbp_decode = 4'h0;
  endfunction

  // ==========================================================================
  // registers
  logic [DBP_A_W-1:0] first_port_input_value_q;
  logic [DBP_A_W-1:0] first_port_output_value_q;
  logic [DBP_A_W-1:0] first_port_direction_q;
  logic [DBP_A_W-1:0] first_port_alt_function_q;
  logic [DBP_B_W-1:0] second_port_input_value_q;
  logic [DBP_B_W-1:0] second_port_output_value_q;
  logic [DBP_B_W-1:0] second_port_direction_q;
  logic [DBP_B_W-1:0] second_port_alt_function_q;

  // ==========================================================================
  // write channel
  logic        aw_held_q;
  logic [11:0] aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic        w_lane0_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        do_wr;
  logic [3:0]  wr_dec;
  logic        wr_en;

  assign s_axi_awready = ~aw_held_q;
  assign s_axi_wready  = ~w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  // the response waits for both halves, so address and data may come in either order
  assign do_wr         = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_dec        = dbp_decode(aw_addr_q);
  // only byte lane 0 holds register data; other lanes are ignored
  assign wr_en         = do_wr & wr_dec[3] & w_lane0_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end
    else if (s_axi_awvalid && !aw_held_q)
    begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (do_wr)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
    end
    else if (s_axi_wvalid && !w_held_q)
    begin
      w_held_q  <= 1'b1;
      w_data_q  <= s_axi_wdata;
      w_lane0_q <= s_axi_wstrb[0];
    end
    else if (do_wr)
      w_held_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= DBP_RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_dec[3] ? DBP_RESP_OKAY : DBP_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // ==========================================================================
  // read channel
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [3:0]  rd_dec;
  logic [7:0]  rd_byte;

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  // decoded as offered; arready stays low while an answer waits, so it cannot change
  assign rd_dec        = dbp_decode(s_axi_araddr);

  always_comb
  begin
    case (rd_dec[2:0])
      DBP_IDX_A_IN[2:0]:  rd_byte = first_port_input_value_q;
      DBP_IDX_A_OUT[2:0]: rd_byte = first_port_output_value_q;
      DBP_IDX_A_DIR[2:0]: rd_byte = first_port_direction_q;
      DBP_IDX_A_SFR[2:0]: rd_byte = first_port_alt_function_q;
      DBP_IDX_B_IN[2:0]:  rd_byte = {3'h0, second_port_input_value_q};
      DBP_IDX_B_OUT[2:0]: rd_byte = {3'h0, second_port_output_value_q};
      DBP_IDX_B_DIR[2:0]: rd_byte = {3'h0, second_port_direction_q};
      DBP_IDX_B_SFR[2:0]: rd_byte = {3'h0, second_port_alt_function_q};
      default:            rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= DBP_RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_dec[3] ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      rresp_q  <= rd_dec[3] ? DBP_RESP_OKAY : DBP_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // ==========================================================================
  // control registers; each holds its bits whatever the direction
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_port_output_value_q <= DBP_RST_OUT;
      first_port_direction_q    <= DBP_RST_DIR;
      first_port_alt_function_q <= DBP_RST_SFR;
    end
    else if (wr_en)
    begin
      case (wr_dec[2:0])
        DBP_IDX_A_OUT[2:0]: first_port_output_value_q <= w_data_q[7:0];
        DBP_IDX_A_DIR[2:0]: first_port_direction_q    <= w_data_q[7:0];
        DBP_IDX_A_SFR[2:0]: first_port_alt_function_q <= w_data_q[7:0];
        default:            first_port_output_value_q <= first_port_output_value_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      second_port_output_value_q <= DBP_RST_OUT[DBP_B_W-1:0];
      second_port_direction_q    <= DBP_RST_DIR[DBP_B_W-1:0];
      second_port_alt_function_q <= DBP_RST_SFR[DBP_B_W-1:0];
    end
    else if (wr_en)
    begin
      case (wr_dec[2:0])
        DBP_IDX_B_OUT[2:0]: second_port_output_value_q <= w_data_q[DBP_B_W-1:0];
        DBP_IDX_B_DIR[2:0]: second_port_direction_q    <= w_data_q[DBP_B_W-1:0];
        DBP_IDX_B_SFR[2:0]: second_port_alt_function_q <= w_data_q[DBP_B_W-1:0];
        default:            second_port_output_value_q <= second_port_output_value_q;
      endcase
    end
  end

  // ==========================================================================
  // input synchronisers; the pad's hysteresis buffer sits ahead of stage one
  logic [DBP_A_W-1:0] a_sync1_q;
  logic [DBP_A_W-1:0] a_sync2_q;
  logic [DBP_B_W-1:0] b_sync1_q;
  logic [DBP_B_W-1:0] b_sync2_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_sync1_q <= '0;
      a_sync2_q <= '0;
      b_sync1_q <= '0;
      b_sync2_q <= '0;
    end
    else
    begin
      a_sync1_q <= first_port_pin_in;
      a_sync2_q <= a_sync1_q;
      b_sync1_q <= second_port_pin_in;
      b_sync2_q <= b_sync1_q;
    end
  end

  // ==========================================================================
  // input value registers, one loop per port
  // a software write wins for one edge; an input bit then reloads from the pin
  genvar gi;

  generate
    for (gi = 0; gi < DBP_A_W; gi++)
    begin : g_a_in
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          first_port_input_value_q[gi] <= DBP_RST_IN[gi];
        else if (wr_en && wr_dec[2:0] == DBP_IDX_A_IN[2:0])
          first_port_input_value_q[gi] <= w_data_q[gi];
        else if (!first_port_direction_q[gi])
          first_port_input_value_q[gi] <= a_sync2_q[gi];
      end
    end

    for (gi = 0; gi < DBP_B_W; gi++)
    begin : g_b_in
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          second_port_input_value_q[gi] <= DBP_RST_IN[gi];
        else if (wr_en && wr_dec[2:0] == DBP_IDX_B_IN[2:0])
          second_port_input_value_q[gi] <= w_data_q[gi];
        else if (!second_port_direction_q[gi])
          second_port_input_value_q[gi] <= b_sync2_q[gi];
      end
    end
  endgenerate

  // ==========================================================================
  // pad drive: first port alternate-function bit selects open drain
  generate
    for (gi = 0; gi < DBP_A_W; gi++)
    begin : g_a_pad
      always_comb
      begin
        if (first_port_alt_function_q[gi])
        begin
          // open drain: pull low only, release for a one
          first_port_pad.out[gi] = 1'b0;
          first_port_pad.oe[gi]  = first_port_direction_q[gi]
                                   & ~first_port_output_value_q[gi];
        end
        else
        begin
          first_port_pad.out[gi] = first_port_output_value_q[gi];
          first_port_pad.oe[gi]  = first_port_direction_q[gi];
        end
      end
    end

    for (gi = 0; gi < DBP_B_W; gi++)
    begin : g_b_pad
      always_comb
      begin
        second_port_pad.oe[gi] = second_port_direction_q[gi];
        if (gi == DBP_B_TMR_BIT && second_port_alt_function_q[gi])
          second_port_pad.out[gi] = timer_zero_output;
        else
          second_port_pad.out[gi] = second_port_output_value_q[gi];
      end
    end
  endgenerate

  // ==========================================================================
  // alternate inputs: only bits set as input with alternate function on
  logic [DBP_B_W-1:0] b_alt_in;
  logic [DBP_B_W-1:0] b_alt_q;

  assign b_alt_in = b_sync2_q & second_port_alt_function_q
                    & ~second_port_direction_q;

  // registered so the consumers see a clean flop, in the same cycle as the input register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      b_alt_q <= '0;
    else
      b_alt_q <= b_alt_in;
  end

  assign comparator_input         = b_alt_q[DBP_B_CMP_BIT];
  assign stop_mode_recovery_input = b_alt_q[DBP_B_SMR_BIT];
  assign external_interrupt_input = b_alt_q[DBP_B_IRQ_LO+1:DBP_B_IRQ_LO];

endmodule

`default_nettype wire

// File: sim/dbp_ports_chk.sv
/*
  dbp_ports_chk: concurrent checks on the ports of dbp_ports.
  Assumes it is bound into dbp_ports and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none

module dbp_ports_chk
  import dbp_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // register bus
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  // pins
  input wire logic [DBP_B_W-1:0] second_port_pin_in,
  input wire dbp_a_pad_t         first_port_pad,
  input wire dbp_b_pad_t         second_port_pad,
  input wire logic               comparator_input,
  input wire logic               stop_mode_recovery_input,
  input wire logic [1:0]         external_interrupt_input
);
  // ==========================================
  // bus handshakes
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence s_w_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence

  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read not answered one cycle after address");
  a_write_answer: assert property (s_w_both |-> ##2 s_axi_bvalid)
    else $error("write not answered two cycles after address and data");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed before taken");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed before taken");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  // ==========================================
  // pads and synchronised alternate inputs
  a_pad_on_write: assert property (!$stable(first_port_pad) |-> $rose(s_axi_bvalid))
    else $error("first port pad moved without a register write");
  a_reset_inputs: assert property ($rose(rst_n) |-> first_port_pad.oe == 8'h00 && second_port_pad.oe == 5'h00)
    else $error("pin driven right after reset");
  a_cmp_sync: assert property (comparator_input |-> $past(second_port_pin_in[0], 3))
    else $error("comparator level not the pin three cycles back");
  a_smr_sync: assert property (stop_mode_recovery_input |-> $past(second_port_pin_in[2], 3))
    else $error("recovery level not the pin three cycles back");
  a_irq_sync: assert property (external_interrupt_input != 2'h0 |-> (external_interrupt_input & ~$past(second_port_pin_in[4:3], 3)) == 2'h0)
    else $error("interrupt level not the pins three cycles back");
endmodule

`default_nettype wire

// File: sim/dbp_pins.sv
/*
  dbp_pins: the circuitry on the pins of both ports.
  Assumes the bench gives per-bit external drive; undriven lines wander.
*/
`timescale 1ns/10ps
`default_nettype none

module dbp_pins
  import dbp_pkg::*;
(
  // clock
  input wire logic        clk,
  // device pads
  input wire dbp_a_pad_t  a_pad,
  input wire dbp_b_pad_t  b_pad,
  // external drive, bit 8 up is the second port
  input wire logic [12:0] ext_val,
  input wire logic [12:0] ext_en,
  // resolved levels
  output logic [12:0]     pin
);
  // ==========================================
  // a floating line toggles so a stale value never passes for a read
  logic [12:0] last_q = 13'h0000;

  always @(posedge clk)
    last_q <= pin;

  assign pin = ({b_pad.oe, a_pad.oe} & {b_pad.out, a_pad.out})
             | (~{b_pad.oe, a_pad.oe} & ext_en & ext_val)
             | (~{b_pad.oe, a_pad.oe} & ~ext_en & ~last_q);
endmodule

`default_nettype wire

// File: sim/testbench.sv
/*
  testbench: self-checking bench for dbp_ports with a pin model and checker.
  Assumes dbp_pkg, dbp_ports, dbp_pins and dbp_ports_chk are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench
  import dbp_pkg::*;
;
  logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, timer_zero_output, comparator_input, stop_mode_recovery_input;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, external_interrupt_input, rsp;
  logic [12:0] pin, ext_val, ext_en;
  logic [7:0]  first_port_pin_in;
  logic [4:0]  second_port_pin_in;
  dbp_a_pad_t  first_port_pad;
  dbp_b_pad_t  second_port_pad;
  int          failures = 0, samples_checked = 0, cycles = 0;
  logic        slow_answer = 1'b0;

  assign first_port_pin_in  = pin[7:0];
  assign second_port_pin_in = pin[12:8];

  dbp_ports i_dbp_ports (.*);
  dbp_pins  i_dbp_pins (.clk, .a_pad(first_port_pad), .b_pad(second_port_pad), .ext_val, .ext_en, .pin);

  // ==========================================
  // bus master and compare
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] resp);
    logic ta, tw, tr, bv;
    @(posedge clk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= !slow_answer;
    do
    begin
      @(negedge clk);
      ta   = s_axi_awvalid & s_axi_awready;
      tw   = s_axi_wvalid & s_axi_wready;
      bv   = s_axi_bvalid;
      tr   = bv & s_axi_bready;
      resp = s_axi_bresp;
      @(posedge clk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (bv && !tr)
        s_axi_bready <= 1'b1;
    end while (!tr);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] resp);
    logic ta, tr, rv;
    @(posedge clk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= !slow_answer;
    do
    begin
      @(negedge clk);
      ta   = s_axi_arvalid & s_axi_arready;
      rv   = s_axi_rvalid;
      tr   = rv & s_axi_rready;
      d    = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ta)
        s_axi_arvalid <= 1'b0;
      if (rv && !tr)
        s_axi_rready <= 1'b1;
    end while (!tr);
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 8; i++)
    begin
      rd(DBP_IDX_A_IN + 10'(i), rdat, rsp);
      chk(rdat, 32'h0);
    end
    chk(32'({first_port_pad.oe, second_port_pad.oe}), 32'h0);
  endtask

  task automatic t_regs();
    logic [9:0] idx;
    for (int i = 1; i < 8; i++)
    begin
      idx = DBP_IDX_A_IN + 10'(i);
      if (i != 4)
      begin
        wr(idx, 8'(8'h3c + i), rsp);
        chk(32'(rsp), 32'(DBP_RESP_OKAY));
        rd(idx, rdat, rsp);
        chk(rdat, (i < 4) ? 32'(8'(8'h3c + i)) : 32'(5'(8'h3c + i)));
      end
    end
  endtask

  task automatic t_push_pull();
    wr(DBP_IDX_A_SFR, 8'h00, rsp);
    wr(DBP_IDX_A_OUT, 8'h3c, rsp);
    wr(DBP_IDX_A_DIR, 8'ha5, rsp);
    chk(32'(first_port_pad.oe), 32'ha5);
    chk(32'(first_port_pad.out & first_port_pad.oe), 32'h24);
    wr(DBP_IDX_A_DIR, 8'hff, rsp);
    chk(32'(first_port_pad.out), 32'h3c);
  endtask

  task automatic t_open_drain();
    wr(DBP_IDX_A_SFR, 8'h0f, rsp);
    chk(32'(first_port_pad.oe), 32'hf3);
    chk(32'(first_port_pad.out), 32'h30);
  endtask

  task automatic t_input();
    ext_val <= 13'h0009;
    wr(DBP_IDX_A_SFR, 8'h00, rsp);
    wr(DBP_IDX_A_DIR, 8'hf0, rsp);
    wr(DBP_IDX_A_OUT, 8'ha0, rsp);
    wr(DBP_IDX_A_IN, 8'h5a, rsp);
    rd(DBP_IDX_A_IN, rdat, rsp);
    chk(rdat, 32'h59);
    rd(DBP_IDX_A_OUT, rdat, rsp);
    chk(rdat, 32'ha0);
  endtask

  task automatic t_alt();
    ext_val           <= 13'h1d09;
    timer_zero_output <= 1'b1;
    wr(DBP_IDX_B_SFR, 8'h1f, rsp);
    wr(DBP_IDX_B_DIR, 8'h02, rsp);
    repeat (4) @(posedge clk);
    chk(32'({second_port_pad.oe, second_port_pad.out & second_port_pad.oe}), 32'h042);
    chk(32'({comparator_input, stop_mode_recovery_input, external_interrupt_input}), 32'hf);
    timer_zero_output <= 1'b0;
    @(posedge clk);
    chk(32'(second_port_pad.out & second_port_pad.oe), 32'h0);
    wr(DBP_IDX_B_SFR, 8'h00, rsp);
    wr(DBP_IDX_B_OUT, 8'h02, rsp);
    chk(32'({second_port_pad.oe, second_port_pad.out & second_port_pad.oe}), 32'h042);
    chk(32'({comparator_input, stop_mode_recovery_input, external_interrupt_input}), 32'h0);
  endtask

  task automatic t_bad();
    wr(10'h0d8, 8'h11, rsp);
    chk(32'(rsp), 32'(DBP_RESP_SLVERR));
    rd(10'h0d8, rdat, rsp);
    chk({rdat[29:0], rsp}, 32'(DBP_RESP_SLVERR));
    // late bready/rready so the answer must stand; lane 0 off means no write
    slow_answer = 1'b1;
    s_axi_wstrb <= 4'he;
    wr(DBP_IDX_B_OUT, 8'h1d, rsp);
    chk(32'(rsp), 32'(DBP_RESP_OKAY));
    s_axi_wstrb <= 4'hf;
    rd(DBP_IDX_B_OUT, rdat, rsp);
    chk(rdat, 32'h02);
    slow_answer = 1'b0;
  endtask

  task automatic t_mid_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({first_port_pad.oe, second_port_pad.oe}), 32'h0);
    rst_n <= 1'b1;
    rd(DBP_IDX_B_DIR, rdat, rsp);
    chk(rdat, 32'h0);
    rd(DBP_IDX_A_SFR, rdat, rsp);
    chk(rdat, 32'h0);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      conclude();
    end
  end

  initial
  begin
    rst_n             = 1'b0;
    s_axi_awaddr      = 12'h000;
    s_axi_araddr      = 12'h000;
    s_axi_wdata       = 32'h0;
    s_axi_wstrb       = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    timer_zero_output = 1'b0;
    ext_en            = 13'h1fff;
    ext_val           = 13'h0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_push_pull();
    t_open_drain();
    t_input();
    t_alt();
    t_bad();
    t_mid_reset();
    conclude();
  end
endmodule

bind dbp_ports dbp_ports_chk i_dbp_ports_chk (.*);

`default_nettype wire
